// File: dv/device_memory_command_handler_test.sv
`timescale 1ns/1ps
// Self-checking bench for the command handler
module device_memory_command_handler_test;
	localparam dmc_pkg::dmc_dev_t AUX = dmc_pkg::DEV_AUX;
	localparam dmc_pkg::dmc_dev_t DAT = dmc_pkg::DEV_DATA;
	localparam dmc_pkg::dmc_dev_t CNT = dmc_pkg::DEV_CNT_VAL;
	logic mclk = 1'b0, srst = 1'b1, reqValid = 1'b0, reqAscii = 1'b0, runSwitch = 1'b0;
	logic wrValid = 1'b0, reqReady, wrReady, memEn, memWe, memWord, memHi, rspValid, rspDone;
	logic runState, remoteActive;
	logic [7:0] reqCmd = 8'h00, reqPoints = 8'h01, rspData, rspCode, lastErr, code;
	logic [15:0] reqHead = 16'h0000, wrHead = 16'h0000, wrData = 16'h0000;
	logic [15:0] memAddr, memWdata, memRdata;
	dmc_pkg::dmc_dev_t reqDev = dmc_pkg::DEV_IN, wrDev = dmc_pkg::DEV_IN, memDev;
	logic [7:0] got[$];
	logic [15:0] wq[$], wh[$];
	int n_fail = 0, tests_run = 0;

	// Model code value is arbitrary
	dmc_cmd_handler #(.MODEL_CODE(8'h3C)) dut (.mclk, .srst, .reqValid, .reqCmd, .reqDev,
		.reqHead, .reqPoints, .reqAscii, .reqReady, .wrValid, .wrDev, .wrHead, .wrData,
		.wrReady, .memEn, .memWe, .memWord, .memHi, .memDev, .memAddr, .memWdata, .memRdata,
		.rspValid, .rspData, .rspDone, .rspCode, .lastErr, .runSwitch, .runState,
		.remoteActive);
	dmc_mem_model mdl (.mclk, .memEn, .memWe, .memWord, .memHi, .memAddr, .memWdata,
		.memRdata);

	// 250 MHz clock
	always #2 mclk = ~mclk;

	function automatic logic [15:0] pat(input logic [7:0] a);
		return {a, ~a};
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic chkq(input logic [7:0] e[$]);
		chk(16'(got.size()), 16'(e.size()));
		foreach (e[i]) chk({8'h00, got[i]}, {8'h00, e[i]});
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic rst_cycle();
		srst = 1'b1;
		repeat (16) @(negedge mclk);
		srst = 1'b0;
		repeat (8) @(negedge mclk);
	endtask

	// Present the head of the write queue, or nothing once it is empty
	task automatic next_wr();
		wrValid = (wq.size() > 0);
		wrData = wrValid ? wq[0] : 16'h0000;
		wrHead = wrValid ? wh[0] : 16'h0000;
	endtask

	// One exchange: request, write items from the queues, bytes collected until done
	task automatic xfer(input logic [7:0] c, input dmc_pkg::dmc_dev_t d,
		input logic [15:0] h, input logic [7:0] p, input logic a);
		int n;
		logic tk, wt, dn;
		n = 0;
		dn = 1'b0;
		got.delete();
		reqCmd = c;
		reqDev = d;
		wrDev = d;
		reqHead = h;
		reqPoints = p;
		reqAscii = a;
		reqValid = 1'b1;
		next_wr();
		while (!dn && n < 2000) begin
			@(posedge mclk);
			tk = reqValid && reqReady;
			wt = wrValid && wrReady;
			dn = rspDone;
			if (rspValid) got.push_back(rspData);
			if (rspDone) code = rspCode;
			@(negedge mclk);
			if (tk) reqValid = 1'b0;
			if (wt) begin
				void'(wq.pop_front());
				void'(wh.pop_front());
			end
			next_wr();
			n++;
		end
		if (!dn) n_fail++;
	endtask

	task automatic t_remote();
		chk(16'(runState), 16'h0000);
		xfer(8'h13, AUX, 16'h0000, 8'h01, 1'b0);
		chk({15'h0000, runState & remoteActive}, 16'h0001);
		xfer(8'h14, AUX, 16'h0000, 8'h01, 1'b0);
		runSwitch = 1'b1;
		repeat (8) @(negedge mclk);
		chk(16'(runState), 16'h0000);
		xfer(8'h14, AUX, 16'h0000, 8'h01, 1'b0);
		xfer(8'h13, AUX, 16'h0000, 8'h01, 1'b0);
		chk({15'h0000, runState & remoteActive}, 16'h0001);
		rst_cycle();
		chk({15'h0000, runState & ~remoteActive}, 16'h0001);
	endtask

	task automatic t_read();
		xfer(8'h00, AUX, 16'h0010, 8'h03, 1'b0);
		chkq('{8'h10, 8'h10});
		xfer(8'h00, AUX, 16'h0010, 8'h03, 1'b1);
		chkq('{8'h31, 8'h30, 8'h31, 8'h30});
		xfer(8'h00, AUX, 16'h0000, 8'h00, 1'b0);
		chk({got[0], 8'(got.size())}, 16'h1080);
		xfer(8'h01, DAT, 16'h0005, 8'h01, 1'b0);
		chkq('{8'hFA, 8'h05});
		xfer(8'h01, DAT, 16'h0005, 8'h01, 1'b1);
		chkq('{8'h30, 8'h35, 8'h46, 8'h41});
		// Octal X020 is index 16, so the group head is aligned
		xfer(8'h01, dmc_pkg::DEV_IN, 16'h0010, 8'h01, 1'b0);
		chkq('{8'hEF, 8'h10});
		xfer(8'h01, AUX, 16'h1F40, 8'h01, 1'b0);
		chkq('{8'hBF, 8'h40});
		// Upper half of each wide counter reads inverted in the memory model
		xfer(8'h01, CNT, 16'h00C8, 8'h02, 1'b0);
		chkq('{8'h37, 8'hC8, 8'hC8, 8'h37});
		chk({8'h00, code}, 16'h0000);
		xfer(8'h15, AUX, 16'h0000, 8'h01, 1'b0);
		chkq('{8'h3C});
		xfer(8'h15, AUX, 16'h0000, 8'h01, 1'b1);
		chkq('{8'h33, 8'h43});
	endtask

	task automatic t_write();
		wq = '{16'h1234, 16'hABCD};
		wh = '{16'h0000, 16'h0000};
		xfer(8'h03, DAT, 16'h0040, 8'h02, 1'b0);
		chk(mdl.mem[8'h40] ^ mdl.mem[8'h41] ^ code, 16'hB9F9);
		// One 16-point group at an aligned head
		wq = '{16'h0F0F};
		wh = '{16'h0000};
		xfer(8'h03, AUX, 16'h0020, 8'h01, 1'b0);
		chk(mdl.mem[8'h20], 16'h0F0F);
		// Three points, pad already stripped before the handler
		wq = '{16'h0000, 16'h0001, 16'h0000};
		wh = '{16'h0000, 16'h0000, 16'h0000};
		xfer(8'h02, AUX, 16'h0060, 8'h03, 1'b0);
		chk({mdl.mem[8'h60][0], mdl.mem[8'h61][0], mdl.mem[8'h62][0]}, 16'h0002);
		wq = '{16'h0000, 16'h0001};
		wh = '{16'h0070, 16'h0073};
		xfer(8'h04, AUX, 16'h0000, 8'h02, 1'b0);
		chk({mdl.mem[8'h70][0], mdl.mem[8'h73][0]}, 16'h0001);
		wq = '{16'h5555, 16'h7777};
		wh = '{16'h0050, 16'h00C8};
		xfer(8'h05, CNT, 16'h0000, 8'h02, 1'b0);
		chk({code, 8'h00}, 16'h5000);
		chk(mdl.mem[8'h50] ^ mdl.mem[8'hC8], 16'h5555 ^ pat(8'hC8));
	endtask

	// Refused requests: code only, no data bytes
	task automatic t_refuse();
		logic [7:0] c [7] = '{8'h07, 8'h00, 8'h01, 8'h01, 8'h03, 8'h01, 8'h01};
		dmc_pkg::dmc_dev_t d [7] = '{AUX, dmc_pkg::DEV_FILE, dmc_pkg::DEV_EXTFILE, CNT, CNT,
			DAT, AUX};
		logic [15:0] h [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h00C8, 16'h00C8, 16'h0000,
			16'h1F41};
		logic [7:0] p [7] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h03, 8'h41, 8'h01};
		logic [7:0] e [7] = '{8'h51, 8'h50, 8'h50, 8'h57, 8'h57, 8'h50, 8'h50};
		for (int i = 0; i < 7; i++) begin
			xfer(c[i], d[i], h[i], p[i], 1'b0);
			chk({code, 8'(got.size())}, {e[i], 8'h00});
			chk({8'h00, lastErr}, {8'h00, e[i]});
		end
	endtask

	initial begin
		rst_cycle();
		t_remote();
		t_read();
		t_write();
		t_refuse();
		tally_and_finish();
	end

	// Whole run needs well under 50000 cycles; this cuts a hang short
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule

// File: dv/dmc_checker.sv
`timescale 1ns/1ps
// Port-level checks on the command handler
module dmc_checker (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// Request and write items
	input  wire logic        reqValid,
	input  wire logic [7:0]  reqCmd,
	input  dmc_pkg::dmc_dev_t reqDev,
	input  wire logic [15:0] reqHead,
	input  wire logic [7:0]  reqPoints,
	input  wire logic        reqReady,
	input  wire logic        wrValid,
	input  dmc_pkg::dmc_dev_t wrDev,
	input  wire logic [15:0] wrHead,
	input  wire logic        wrReady,
	// Memory, answer and state
	input  wire logic        memEn,
	input  wire logic        memWe,
	input  dmc_pkg::dmc_dev_t memDev,
	input  wire logic        rspDone,
	input  wire logic [7:0]  rspCode,
	input  wire logic        runState,
	input  wire logic        remoteActive
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	logic       take;
	logic [7:0] cmdQ;

	// Request accepted this cycle
	assign take = reqValid && reqReady;

	// Command of the exchange in progress, needed to judge write items
	always_ff @(posedge mclk) begin
		if (srst) begin
			cmdQ <= 8'h00;
		end else if (take) begin
			cmdQ <= reqCmd;
		end
	end

	sequence answer(logic [7:0] c);
		##[1:4] (rspDone && rspCode == c);
	endsequence

	sequence forced(logic r);
		##[2:5] (runState == r && remoteActive);
	endsequence

	take_holds_a:
		assert property (take |=> !reqReady) else $error("ready stayed high after a take");
	bad_cmd_a:
		assert property (take && !(reqCmd inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
			8'h05, 8'h13, 8'h14, 8'h15}) |-> answer(8'h51)) else $error("unknown command kept");
	file_refused_a:
		assert property (take && reqCmd inside {8'h00, 8'h01, 8'h02, 8'h03} && reqDev inside
			{dmc_pkg::DEV_FILE, dmc_pkg::DEV_EXTFILE} |-> answer(8'h50)) else $error("file access");
	mem_dev_a:
		assert property (memEn |-> !(memDev inside {dmc_pkg::DEV_FILE, dmc_pkg::DEV_EXTFILE}))
			else $error("memory access to a file register");
	cnt32_odd_a:
		assert property (take && reqCmd inside {8'h01, 8'h03} && reqDev == dmc_pkg::DEV_CNT_VAL
			&& reqHead >= 16'h00C8 && reqPoints[0] |-> answer(8'h57)) else $error("odd count taken");
	word_limit_a:
		assert property (take && reqCmd == 8'h01 && reqDev == dmc_pkg::DEV_DATA
			&& (reqPoints > 8'h40 || reqPoints == 8'h00) |-> answer(8'h50)) else $error("limit");
	run_force_a:
		assert property (take && reqCmd == 8'h13 |-> forced(1'b1)) else $error("run not forced");
	stop_force_a:
		assert property (take && reqCmd == 8'h14 |-> forced(1'b0)) else $error("stop not forced");
	rand_cnt32_a:
		assert property (wrValid && wrReady && cmdQ == 8'h05 && wrDev == dmc_pkg::DEV_CNT_VAL
			&& wrHead >= 16'h00C8 |=> !memWe) else $error("wide counter written");
	reset_clear_a:
		assert property ($fell(srst) |-> !remoteActive && !runState) else $error("remote kept");
endmodule

bind dmc_cmd_handler dmc_checker chk (.mclk, .srst, .reqValid, .reqCmd, .reqDev, .reqHead,
	.reqPoints, .reqReady, .wrValid, .wrDev, .wrHead, .wrReady, .memEn, .memWe, .memDev,
	.rspDone, .rspCode, .runState, .remoteActive);

// File: dv/dmc_mem_model.sv
`timescale 1ns/1ps
// Behavioural device memory behind the handler's memory port
module dmc_mem_model (
	// Clock
	input  wire logic        mclk,
	// Memory port driven by the handler
	input  wire logic        memEn,
	input  wire logic        memWe,
	input  wire logic        memWord,
	input  wire logic        memHi,
	input  wire logic [15:0] memAddr,
	input  wire logic [15:0] memWdata,
	output logic [15:0]      memRdata
);
	logic [15:0] mem [0:255];
	logic [15:0] rdQ;
	logic [1:0]  ageQ;

	// Known pattern so every read has a predictable value
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = {i[7:0], ~i[7:0]};
		end
		rdQ = 16'h0000;
		ageQ = 2'd3;
	end

	// bit or word
	// Bit writes touch only bit 0, word and group writes the whole location
	// Upper half of a wide counter reads inverted, so a wrong half select shows up
	always @(posedge mclk) begin
		if (memEn && memWe && memWord) begin
			mem[memAddr[7:0]] <= memWdata;
		end else if (memEn && memWe) begin
			mem[memAddr[7:0]][0] <= memWdata[0];
		end
		if (memEn) begin
			rdQ <= memHi ? ~mem[memAddr[7:0]] : mem[memAddr[7:0]];
			ageQ <= 2'd0;
		end else if (ageQ != 2'd3) begin
			ageQ <= ageQ + 2'd1;
		end
	end

	// Data inverts once the hold window is over, so a late sample is caught
	assign memRdata = (ageQ < 2'd3) ? rdQ : ~rdQ;
endmodule

// File: rtl/dmc_cmd_handler.sv
`timescale 1ns/1ps
module dmc_cmd_handler #(
	parameter logic [7:0] MODEL_CODE = 8'hA5 // Arbitrary model-name code
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              srst,
	// Decoded request
	input  wire logic              reqValid,
	input  wire logic [7:0]        reqCmd,
	input  dmc_pkg::dmc_dev_t      reqDev,
	input  wire logic [15:0]       reqHead,
	input  wire logic [7:0]        reqPoints,
	input  wire logic              reqAscii,
	output logic                   reqReady,
	// Write points and random-write items
	input  wire logic              wrValid,
	input  dmc_pkg::dmc_dev_t      wrDev,
	input  wire logic [15:0]       wrHead,
	input  wire logic [15:0]       wrData,
	output logic                   wrReady,
	// Device memory port, read data one cycle after memEn
	output logic                   memEn,
	output logic                   memWe,
	output logic                   memWord,
	output logic                   memHi,
	output dmc_pkg::dmc_dev_t      memDev,
	output logic [15:0]            memAddr,
	output logic [15:0]            memWdata,
	input  wire logic [15:0]       memRdata,
	// Response stream
	output logic                   rspValid,
	output logic [7:0]             rspData,
	output logic                   rspDone,
	output logic [7:0]             rspCode,
	output logic [7:0]             lastErr,
	// Operating state
	input  wire logic              runSwitch,
	output logic                   runState,
	output logic                   remoteActive
);
	dmc_pkg::dmc_state_t  state_q;
	dmc_pkg::dmc_remote_t remote_q;
	dmc_pkg::dmc_dev_t    dev_q;
	logic [7:0]  cmd_q;
	logic [15:0] head_q;
	logic [8:0]  pts_q;
	logic        ascii_q;
	logic [8:0]  idx_q;
	logic [3:0]  nib_q;
	logic [7:0]  err_q;
	logic [31:0] out_q;
	logic [2:0]  outCnt_q;
	logic        switchLvl;

	function automatic logic isBitDev(input dmc_pkg::dmc_dev_t d);
		isBitDev = (d == dmc_pkg::DEV_IN) || (d == dmc_pkg::DEV_OUT) ||
			(d == dmc_pkg::DEV_AUX) || (d == dmc_pkg::DEV_STEP) ||
			(d == dmc_pkg::DEV_TMR_CT) || (d == dmc_pkg::DEV_CNT_CT);
	endfunction

	function automatic logic isWordDev(input dmc_pkg::dmc_dev_t d);
		isWordDev = (d == dmc_pkg::DEV_TMR_VAL) || (d == dmc_pkg::DEV_CNT_VAL) ||
			(d == dmc_pkg::DEV_DATA) || (d == dmc_pkg::DEV_EXT);
	endfunction

	// Span must stay in one area; special and 32-bit areas are never crossed into
	function automatic logic inRange(input dmc_pkg::dmc_dev_t d, input logic [15:0] h,
		input logic [12:0] span);
		logic [16:0] last;
		logic        low;
		last = {1'b0, h} + {4'b0, span} - 17'h0_0001;
		low  = h < dmc_pkg::SPECIAL_BASE;
		case (d)
			dmc_pkg::DEV_IN, dmc_pkg::DEV_OUT: inRange = last <= {1'b0, dmc_pkg::IO_MAX};
			dmc_pkg::DEV_AUX: inRange = low ? (last <= {1'b0, dmc_pkg::AUX_MAX}) :
				(last <= {1'b0, dmc_pkg::SPECIAL_TOP});
			dmc_pkg::DEV_STEP: inRange = last <= {1'b0, dmc_pkg::STEP_MAX};
			dmc_pkg::DEV_TMR_CT, dmc_pkg::DEV_TMR_VAL: inRange = last <= {1'b0, dmc_pkg::TMR_MAX};
			dmc_pkg::DEV_CNT_CT, dmc_pkg::DEV_CNT_VAL:
				inRange = (h < dmc_pkg::CNT32_BASE) ? (last < {1'b0, dmc_pkg::CNT32_BASE}) :
					(last <= {1'b0, dmc_pkg::CNT_MAX});
			dmc_pkg::DEV_DATA: inRange = low ? (last <= {1'b0, dmc_pkg::DATA_MAX}) :
				(last <= {1'b0, dmc_pkg::SPECIAL_TOP});
			dmc_pkg::DEV_EXT: inRange = last <= {1'b0, dmc_pkg::EXT_MAX};
			default: inRange = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] hexChar(input logic [3:0] v);
		hexChar = (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
	endfunction

	dmc_pin_sync uSwitch (
		.mclk  (mclk),
		.srst  (srst),
		.pinIn (runSwitch),
		.level (switchLvl)
	);

	// Command class decode
	wire isBitBatch  = (cmd_q == dmc_pkg::CMD_BIT_READ) || (cmd_q == dmc_pkg::CMD_BIT_WRITE);
	wire isWordBatch = (cmd_q == dmc_pkg::CMD_WORD_READ) || (cmd_q == dmc_pkg::CMD_WORD_WRITE);
	wire isRand      = (cmd_q == dmc_pkg::CMD_BIT_RAND) || (cmd_q == dmc_pkg::CMD_WORD_RAND);
	wire isRead      = (cmd_q == dmc_pkg::CMD_BIT_READ) || (cmd_q == dmc_pkg::CMD_WORD_READ);
	wire isCtl       = (cmd_q == dmc_pkg::CMD_RUN) || (cmd_q == dmc_pkg::CMD_STOP) ||
		(cmd_q == dmc_pkg::CMD_MODEL);
	wire bitDev      = isBitDev(dev_q);
	wire wordDev     = isWordDev(dev_q);
	wire is32        = (dev_q == dmc_pkg::DEV_CNT_VAL) && (head_q >= dmc_pkg::CNT32_BASE);
	wire grpUnit     = isWordBatch && bitDev;
	wire lastPt      = idx_q == (pts_q - 9'h001);

	wire [8:0] reqPts = (reqPoints == 8'h00) ? dmc_pkg::PTS_FULL : {1'b0, reqPoints};

	// Span and point limit of a batch request
	wire [12:0] span = grpUnit ? {pts_q, 4'h0} : (is32 ? {5'h00, pts_q[8:1]} : {4'h0, pts_q});
	wire [8:0] limit =
		(cmd_q == dmc_pkg::CMD_BIT_READ)  ? dmc_pkg::LIM_BIT_READ :
		(cmd_q == dmc_pkg::CMD_BIT_WRITE) ? dmc_pkg::LIM_BIT_WRITE :
		(cmd_q == dmc_pkg::CMD_BIT_RAND)  ? dmc_pkg::LIM_BIT_RAND :
		(cmd_q == dmc_pkg::CMD_WORD_RAND) ? dmc_pkg::LIM_WORD_RAND :
		grpUnit ? (isRead ? dmc_pkg::LIM_GRP_READ : dmc_pkg::LIM_GRP_WRITE) : dmc_pkg::LIM_WORD;

	// special relays at 8000 plus 16n
	wire headAligned = head_q[3:0] == 4'h0;
	wire cnt32Odd    = isWordBatch && is32 && pts_q[0];
	wire batchOk = (pts_q <= limit) && inRange(dev_q, head_q, span) &&
		((isBitBatch && bitDev) || (isWordBatch && (wordDev || (bitDev && headAligned))));
	wire reqOk   = isCtl || (isRand && (pts_q <= limit)) || (batchOk && !cnt32Odd);
	wire [7:0] reqErr = cnt32Odd ? dmc_pkg::ERR_CNT32 :
		((isBitBatch || isWordBatch || isRand) ? dmc_pkg::ERR_RANGE : dmc_pkg::ERR_CMD);

	// no 32-bit counters by word random write
	wire itemIs32 = (wrDev == dmc_pkg::DEV_CNT_VAL) && (wrHead >= dmc_pkg::CNT32_BASE);
	wire itemGrp  = (cmd_q == dmc_pkg::CMD_WORD_RAND) && isBitDev(wrDev);
	wire itemOk   = (cmd_q == dmc_pkg::CMD_BIT_RAND) ?
		(isBitDev(wrDev) && inRange(wrDev, wrHead, 13'h0001)) :
		(((isWordDev(wrDev) && !itemIs32) || (itemGrp && wrHead[3:0] == 4'h0)) &&
		inRange(wrDev, wrHead, itemGrp ? 13'h0010 : 13'h0001));
	wire wrTake   = wrValid && wrReady;

	// Point address for batch access
	wire [15:0] pointAddr = is32 ? head_q + {8'h00, idx_q[8:1]} :
		(grpUnit ? head_q + {3'b000, idx_q, 4'h0} : head_q + {7'h00, idx_q});

	// Read data formatting
	wire        rdBit   = memRdata[0];
	wire [31:0] asciiWd = {hexChar(memRdata[15:12]), hexChar(memRdata[11:8]),
		hexChar(memRdata[7:4]), hexChar(memRdata[3:0])};
	wire        oddTail = lastPt && !idx_q[0];

	// Handler sequence
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q  <= dmc_pkg::ST_IDLE;
			remote_q <= dmc_pkg::RM_NONE;
			dev_q    <= dmc_pkg::DEV_IN;
			cmd_q    <= 8'h00;
			head_q   <= 16'h0000;
			pts_q    <= 9'h000;
			ascii_q  <= 1'b0;
			idx_q    <= 9'h000;
			nib_q    <= 4'h0;
			err_q    <= dmc_pkg::ERR_NONE;
			out_q    <= 32'h0000_0000;
			outCnt_q <= 3'h0;
			reqReady <= 1'b1;
			wrReady  <= 1'b0;
			memEn    <= 1'b0;
			memWe    <= 1'b0;
			memWord  <= 1'b0;
			memHi    <= 1'b0;
			memDev   <= dmc_pkg::DEV_IN;
			memAddr  <= 16'h0000;
			memWdata <= 16'h0000;
			rspValid <= 1'b0;
			rspData  <= 8'h00;
			rspDone  <= 1'b0;
			rspCode  <= dmc_pkg::ERR_NONE;
			lastErr  <= dmc_pkg::ERR_NONE;
		end else begin
			memEn    <= 1'b0;
			memWe    <= 1'b0;
			rspValid <= 1'b0;
			rspDone  <= 1'b0;
			case (state_q)
				dmc_pkg::ST_IDLE: begin
					if (reqValid) begin
						cmd_q    <= reqCmd;
						dev_q    <= reqDev;
						head_q   <= reqHead;
						pts_q    <= reqPts;
						ascii_q  <= reqAscii;
						idx_q    <= 9'h000;
						err_q    <= dmc_pkg::ERR_NONE;
						reqReady <= 1'b0;
						state_q  <= dmc_pkg::ST_CHECK;
					end
				end
				dmc_pkg::ST_CHECK: begin
					if (!reqOk) begin
						err_q   <= reqErr;
						state_q <= dmc_pkg::ST_DONE;
					end else if (cmd_q == dmc_pkg::CMD_RUN) begin
						remote_q <= dmc_pkg::RM_RUN;
						state_q  <= dmc_pkg::ST_DONE;
					end else if (cmd_q == dmc_pkg::CMD_STOP) begin
						remote_q <= dmc_pkg::RM_STOP;
						state_q  <= dmc_pkg::ST_DONE;
					end else if (cmd_q == dmc_pkg::CMD_MODEL) begin
						out_q    <= ascii_q ? {hexChar(MODEL_CODE[7:4]), hexChar(MODEL_CODE[3:0]),
							16'h0000} : {MODEL_CODE, 24'h00_0000};
						outCnt_q <= ascii_q ? 3'h2 : 3'h1;
						state_q  <= dmc_pkg::ST_EMIT;
					end else if (isRead) begin
						state_q <= dmc_pkg::ST_ISSUE;
					end else begin
						wrReady <= 1'b1;
						state_q <= dmc_pkg::ST_WRITE;
					end
				end
				dmc_pkg::ST_ISSUE: begin
					memEn   <= 1'b1;
					memWord <= grpUnit || !bitDev;
					memHi   <= is32 && idx_q[0];
					memDev  <= dev_q;
					memAddr <= pointAddr;
					state_q <= dmc_pkg::ST_MEM;
				end
				dmc_pkg::ST_MEM: begin
					state_q <= dmc_pkg::ST_CAPT;
				end
				dmc_pkg::ST_CAPT: begin
					state_q <= dmc_pkg::ST_EMIT;
					if (cmd_q == dmc_pkg::CMD_BIT_READ && ascii_q) begin
						out_q    <= {dmc_pkg::ASCII_ZERO | {7'h00, rdBit},
							oddTail ? dmc_pkg::ASCII_ZERO : 8'h00, 16'h0000};
						outCnt_q <= oddTail ? 3'h2 : 3'h1;
					end else if (cmd_q == dmc_pkg::CMD_BIT_READ && !idx_q[0] && !lastPt) begin
						// Two points share a byte, so hold the first nibble
						nib_q   <= {3'b000, rdBit};
						idx_q   <= idx_q + 9'h001;
						state_q <= dmc_pkg::ST_ISSUE;
					end else if (cmd_q == dmc_pkg::CMD_BIT_READ) begin
						out_q    <= {idx_q[0] ? {nib_q, 3'b000, rdBit} :
							{3'b000, rdBit, dmc_pkg::PAD_NIBBLE}, 24'h00_0000};
						outCnt_q <= 3'h1;
					end else if (ascii_q) begin
						out_q    <= asciiWd;
						outCnt_q <= 3'h4;
					end else begin
						out_q    <= {memRdata[7:0], memRdata[15:8], 16'h0000};
						outCnt_q <= 3'h2;
					end
				end
				dmc_pkg::ST_EMIT: begin
					rspValid <= 1'b1;
					rspData  <= out_q[31:24];
					out_q    <= {out_q[23:0], 8'h00};
					outCnt_q <= outCnt_q - 3'h1;
					if (outCnt_q == 3'h1) begin
						if (lastPt || cmd_q == dmc_pkg::CMD_MODEL) begin
							state_q <= dmc_pkg::ST_DONE;
						end else begin
							idx_q   <= idx_q + 9'h001;
							state_q <= dmc_pkg::ST_ISSUE;
						end
					end
				end
				// Writes take one point or item per cycle while wrReady is high
				dmc_pkg::ST_WRITE: begin
					if (wrTake) begin
						if (!isRand || itemOk) begin
							memEn    <= 1'b1;
							memWe    <= 1'b1;
							memWdata <= wrData;
						end else if (err_q == dmc_pkg::ERR_NONE) begin
							err_q <= dmc_pkg::ERR_RANGE;
						end
						memDev  <= isRand ? wrDev : dev_q;
						memAddr <= isRand ? wrHead : pointAddr;
						memWord <= isRand ? (cmd_q == dmc_pkg::CMD_WORD_RAND) : (grpUnit || !bitDev);
						memHi   <= !isRand && is32 && idx_q[0];
						if (lastPt) begin
							wrReady <= 1'b0;
							state_q <= dmc_pkg::ST_DONE;
						end else begin
							idx_q <= idx_q + 9'h001;
						end
					end
				end
				dmc_pkg::ST_DONE: begin
					rspDone  <= 1'b1;
					rspCode  <= err_q;
					reqReady <= 1'b1;
					if (err_q != dmc_pkg::ERR_NONE) begin
						lastErr <= err_q;
					end
					state_q <= dmc_pkg::ST_IDLE;
				end
				default: begin
					state_q <= dmc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Operating state; reset stands for power-up and drops remote control
	always_ff @(posedge mclk) begin
		if (srst) begin
			runState     <= 1'b0;
			remoteActive <= 1'b0;
		end else begin
			remoteActive <= remote_q != dmc_pkg::RM_NONE;
			case (remote_q)
				dmc_pkg::RM_RUN:  runState <= 1'b1;
				dmc_pkg::RM_STOP: runState <= 1'b0;
				default:          runState <= switchLvl;
			endcase
		end
	end
endmodule

// File: rtl/dmc_pin_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; the level moves only when stages two and three agree
module dmc_pin_sync (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic srst,
	// Pin and clean level
	input  wire logic pinIn,
	output logic      level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// First stage only feeds the second, to keep metastability contained
	always_ff @(posedge mclk) begin
		if (srst) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level <= s3_q;
			end
		end
	end
endmodule

// File: rtl/dmc_pkg.sv
package dmc_pkg;

	// Command codes carried in the request
	localparam logic [7:0] CMD_BIT_READ   = 8'h00;
	localparam logic [7:0] CMD_WORD_READ  = 8'h01;
	localparam logic [7:0] CMD_BIT_WRITE  = 8'h02;
	localparam logic [7:0] CMD_WORD_WRITE = 8'h03;
	localparam logic [7:0] CMD_BIT_RAND   = 8'h04;
	localparam logic [7:0] CMD_WORD_RAND  = 8'h05;
	localparam logic [7:0] CMD_RUN        = 8'h13;
	localparam logic [7:0] CMD_STOP       = 8'h14;
	localparam logic [7:0] CMD_MODEL      = 8'h15;

	// Device selector decoded from the two-character device code
	typedef enum logic [3:0] {
		DEV_IN      = 4'b0000,
		DEV_OUT     = 4'b0001,
		DEV_AUX     = 4'b0010,
		DEV_STEP    = 4'b0011,
		DEV_TMR_CT  = 4'b0100,
		DEV_CNT_CT  = 4'b0101,
		DEV_TMR_VAL = 4'b0110,
		DEV_CNT_VAL = 4'b0111,
		DEV_DATA    = 4'b1000,
		DEV_EXT     = 4'b1001,
		DEV_FILE    = 4'b1010,
		DEV_EXTFILE = 4'b1011
	} dmc_dev_t;

	// Highest device numbers and area bases
	localparam logic [15:0] IO_MAX       = 16'h00FF;
	localparam logic [15:0] AUX_MAX      = 16'h1DFF;
	localparam logic [15:0] STEP_MAX     = 16'h0FFF;
	localparam logic [15:0] TMR_MAX      = 16'h01FF;
	localparam logic [15:0] CNT_MAX      = 16'h00FF;
	localparam logic [15:0] DATA_MAX     = 16'h1F3F;
	localparam logic [15:0] EXT_MAX      = 16'h7FFF;
	localparam logic [15:0] SPECIAL_BASE = 16'h1F40;
	localparam logic [15:0] SPECIAL_TOP  = 16'h213F;
	localparam logic [15:0] CNT32_BASE   = 16'h00C8;

	// Point limits per exchange
	localparam logic [8:0] LIM_BIT_READ   = 9'h100;
	localparam logic [8:0] LIM_BIT_WRITE  = 9'h0A0;
	localparam logic [8:0] LIM_WORD       = 9'h040;
	localparam logic [8:0] LIM_GRP_READ   = 9'h020;
	localparam logic [8:0] LIM_GRP_WRITE  = 9'h00A;
	localparam logic [8:0] LIM_BIT_RAND   = 9'h050;
	localparam logic [8:0] LIM_WORD_RAND  = 9'h00A;
	localparam logic [8:0] PTS_FULL       = 9'h100;

	// Answer codes and fill values
	localparam logic [7:0] ERR_NONE   = 8'h00;
	localparam logic [7:0] ERR_RANGE  = 8'h50;
	localparam logic [7:0] ERR_CMD    = 8'h51;
	localparam logic [7:0] ERR_CNT32  = 8'h57;
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	localparam logic [3:0] PAD_NIBBLE = 4'h0;

	// Remote operating mode
	typedef enum logic [1:0] {
		RM_NONE = 2'b00,
		RM_RUN  = 2'b01,
		RM_STOP = 2'b10
	} dmc_remote_t;

	// Handler states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CHECK = 3'b001,
		ST_ISSUE = 3'b010,
		ST_MEM   = 3'b011,
		ST_CAPT  = 3'b100,
		ST_EMIT  = 3'b101,
		ST_WRITE = 3'b110,
		ST_DONE  = 3'b111
	} dmc_state_t;

endpackage
